// file: core/snv_dev.sv
// device end: serial slave in front of a byte-wide nonvolatile array
// assumes link pins are asynchronous; they are synchronised here
`timescale 1ns/1ps
module snv_dev #(
	parameter int         AW      = snv_pkg::ADDR_W,
	parameter logic [5:0] SR_RST  = snv_pkg::SR_INIT,
	parameter logic [63:0] SN_RST = snv_pkg::SER_INIT
) (
	// clock and reset
	input  wire logic i_clk_sys,
	input  wire logic i_nrst,
	// link
	snv_if.dev        bus,
	// user side status
	output      logic o_active,
	output      logic o_write_latch,
	output      logic o_status_protect_enable_bit
);
	import snv_pkg::*;
	localparam int DEPTH = 1 << AW;
	typedef struct packed {
		logic [1:0]  sck_s;
		logic        sck_d;
		logic [1:0]  cs_s;
		logic [1:0]  si_s;
		logic [1:0]  wp_s;
		snv_dst_t    st;
		logic [2:0]  bitc;
		logic [1:0]  abyte;
		logic [7:0]  rx;
		logic [7:0]  tx;
		logic [7:0]  op;
		logic [23:0] addr;
		logic [7:2]  sr;
		logic        latch;
		logic [63:0] ser;
		logic        so;
		logic        so_oe_n;
		logic        we;
		logic [AW-1:0] wa;
		logic [7:0]  wd;
		logic        active;
	} snv_dev_st_t;
	snv_dev_st_t r;
	snv_dev_st_t next_r;
	logic [7:0] mem [0:DEPTH-1];
	logic        rise;
	logic        fall;
	logic        sel;
	logic [7:0]  rxb;
	logic [23:0] nad;
	logic [23:0] nxa;
	////////////////////////////////////////////////////////////////
	// byte of the serial number, first byte is the top one
	function automatic logic [7:0] ser_get(input logic [63:0] s,
		input logic [2:0] idx);
		logic [7:0] b;
		b = 8'h00;
		for (int k = 0; k < 8; k++)
			if (idx == 3'(k))
				b = s[8*(7-k) +: 8];
		return b;
	endfunction
	function automatic logic [63:0] ser_put(input logic [63:0] s,
		input logic [2:0] idx, input logic [7:0] b);
		logic [63:0] o;
		o = s;
		for (int k = 0; k < 8; k++)
			if (idx == 3'(k))
				o[8*(7-k) +: 8] = b;
		return o;
	endfunction
	// byte to send next for the current read command
	function automatic logic [7:0] rd_byte(input snv_dev_st_t s,
		input logic [23:0] a);
		if (s.op == OP_RD_STAT)
			return {s.sr, s.latch, 1'b0};
		else if (s.op == OP_RD_SER)
			return ser_get(s.ser, a[2:0]);
		else
			return mem[a[AW-1:0]]; // [R10]
	endfunction
	////////////////////////////////////////////////////////////////
	// edge finding on synchronised pins and the command engine
	always_comb begin
		next_r       = r;
		next_r.we    = 1'b0;
		next_r.sck_s = {r.sck_s[0], bus.sck};
		next_r.cs_s  = {r.cs_s[0], bus.cs_n};
		next_r.si_s  = {r.si_s[0], bus.mosi};
		next_r.wp_s  = {r.wp_s[0], bus.wp_n};
		next_r.sck_d = r.sck_s[1];
		rise = r.sck_s[1] & ~r.sck_d; // [R6]
		fall = ~r.sck_s[1] & r.sck_d;
		sel  = ~r.cs_s[1];
		rxb  = {r.rx[6:0], r.si_s[1]}; // [R16]
		nad  = r.addr + 24'h000001;
		nxa  = {r.addr[15:0], rxb};
		next_r.active = sel;
		if (!sel) begin
			// standby: drop any partial command [R1] [R15] [R13]
			next_r.st      = D_CMD;
			next_r.bitc    = 3'h0;
			next_r.abyte   = 2'h0;
			next_r.so      = 1'b0;
			next_r.so_oe_n = 1'b1;
		end else begin
			// output changes only on falling edges in a read [R5] [R17]
			if (fall && r.st == D_RD) begin
				next_r.so      = r.tx[7]; // [R8]
				next_r.so_oe_n = 1'b0;
			end
			// input sampled on rising edges [R2] [R4]
			if (rise) begin
				next_r.rx   = rxb;
				next_r.bitc = r.bitc + 3'h1;
				if (r.st == D_RD)
					next_r.tx = {r.tx[6:0], 1'b0};
				if (r.bitc == BIT_LAST) begin
					case (r.st)
					D_CMD: begin
						next_r.op   = rxb;
						next_r.addr = 24'h000000;
						case (rxb)
						OP_WR_EN:   next_r.st = D_SKIP;
						OP_WR_DIS:  next_r.st = D_SKIP;
						OP_RD_STAT: next_r.st = D_RD;
						OP_WR_STAT: next_r.st = D_WSTAT;
						OP_RD_MEM:  next_r.st = D_ADDR;
						OP_WR_MEM:  next_r.st = D_ADDR;
						OP_RD_SER:  next_r.st = D_RD; // [R11]
						OP_WR_SER:  next_r.st = D_WSER;
						default:    next_r.st = D_SKIP;
						endcase
						if (rxb == OP_WR_EN)
							next_r.latch = 1'b1;
						if (rxb == OP_WR_DIS)
							next_r.latch = 1'b0;
						if (rxb == OP_RD_STAT)
							next_r.tx = {r.sr, r.latch, 1'b0};
						if (rxb == OP_RD_SER)
							next_r.tx = ser_get(r.ser, 3'h0);
					end
					D_ADDR: begin
						next_r.addr  = nxa;
						next_r.abyte = r.abyte + 2'h1;
						if (r.abyte == ADDR_LAST) begin
							if (r.op == OP_RD_MEM) begin
								next_r.st = D_RD;
								next_r.tx = mem[nxa[AW-1:0]]; // [R10]
							end else
								next_r.st = D_WMEM;
						end
					end
					D_WMEM: begin
						// write lands at once, no busy time [R12]
						next_r.we   = r.latch;
						next_r.wa   = r.addr[AW-1:0];
						next_r.wd   = rxb;
						next_r.addr = nad;
					end
					D_RD: begin
						next_r.addr = nad;
						next_r.tx   = rd_byte(r, nad); // [R8]
					end
					D_WSTAT: begin
						// protect pin low plus protect bit blocks [R9]
						if (r.latch && !(r.sr[SR_PROT] && !r.wp_s[1]))
							next_r.sr = rxb[7:2];
						next_r.st = D_SKIP;
					end
					D_WSER: begin
						if (r.latch)
							next_r.ser = ser_put(r.ser, r.addr[2:0],
								rxb); // [R11]
						next_r.addr = nad;
						if (r.addr[2:0] == SER_LAST)
							next_r.st = D_SKIP;
					end
					default: next_r.st = D_SKIP;
					endcase
				end
			end
		end
	end
	////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			r         <= '0;
			r.cs_s    <= 2'b11;
			r.wp_s    <= 2'b11;
			r.so_oe_n <= 1'b1;
			r.sr      <= SR_RST;
			r.ser     <= SN_RST;
		end else
			r <= next_r;
	end
	// array write port, no reset on storage
	always_ff @(posedge i_clk_sys) begin
		if (r.we)
			mem[r.wa] <= r.wd;
	end
	////////////////////////////////////////////////////////////////
	// outputs straight from the state register
	assign bus.miso      = r.so;
	assign bus.miso_oe_n = r.so_oe_n; // [R1] [R17]
	assign o_active      = r.active;
	assign o_write_latch = r.latch;
	assign o_status_protect_enable_bit = r.sr[SR_PROT];
endmodule

// file: core/snv_pkg.sv
// shared constants and types for the serial nonvolatile memory link
// assumes both ends and the fifo run on one system clock of 250 MHz
//
// How it works
// R1 - deselected: standby, output off, inputs ignored
// R2 - selected: take input, drive output per command
// R3 - host lowers select before first command bit
// R4 - device samples input on clock rising edge
// R5 - device changes output on clock falling edge
// R6 - only clock modes 0 and 3
// R7 - host sends command, address, then write data
// R8 - device returns memory and status data serially
// R9 - status write gated by protect pin and bit
// R10 - array decodes 262,144 byte addresses
// R11 - separate 64-bit serial number, own commands
// R12 - writes finish at once, no busy wait
// R13 - device is slave only, own select each
// R14 - host may share data line when idle
// R15 - short command code executes nothing
// R16 - all fields shifted most significant bit first
// R17 - output off during command, address, write data
package snv_pkg;
	////////////////////////////////////////////////////////////////
	// command codes
	localparam logic [7:0] OP_WR_EN   = 8'h06;
	localparam logic [7:0] OP_WR_DIS  = 8'h04;
	localparam logic [7:0] OP_RD_STAT = 8'h05;
	localparam logic [7:0] OP_WR_STAT = 8'h01;
	localparam logic [7:0] OP_RD_MEM  = 8'h03;
	localparam logic [7:0] OP_WR_MEM  = 8'h02;
	localparam logic [7:0] OP_RD_SER  = 8'hc3;
	localparam logic [7:0] OP_WR_SER  = 8'hc2;
	////////////////////////////////////////////////////////////////
	// sizes and field positions
	localparam int         ADDR_W     = 18;
	localparam logic [2:0] BIT_LAST   = 3'h7;
	localparam logic [1:0] ADDR_LAST  = 2'h2;
	localparam logic [2:0] SER_LAST   = 3'h7;
	localparam int         SR_PROT    = 7;
	localparam logic [5:0] SR_INIT    = 6'h00;
	localparam logic [63:0] SER_INIT  = 64'h0011223344556677; // arbitrary
	////////////////////////////////////////////////////////////////
	// timing of the serial clock made by the host
	localparam int SYS_PERIOD_NS = 4;
	localparam int SCK_PERIOD_NS = 64;
	localparam int SCK_HALF_CYC  = SCK_PERIOD_NS / (2 * SYS_PERIOD_NS);
	////////////////////////////////////////////////////////////////
	// states
	typedef enum logic [2:0] {
		D_CMD   = 3'b000,
		D_ADDR  = 3'b001,
		D_WMEM  = 3'b010,
		D_RD    = 3'b011,
		D_WSTAT = 3'b100,
		D_WSER  = 3'b101,
		D_SKIP  = 3'b110
	} snv_dst_t;
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_LOAD = 3'b001,
		H_LO   = 3'b010,
		H_HI   = 3'b011,
		H_TAIL = 3'b100,
		H_END  = 3'b101,
		H_GAP  = 3'b110
	} snv_hst_t;
endpackage

// file: core/snv_if.sv
// wires of the four-wire serial link plus write protect
// assumes the bench connects one host end and one device end
`timescale 1ns/1ps
interface snv_if;
	logic cs_n;
	logic sck;
	logic mosi;
	logic miso;
	logic miso_oe_n;
	logic wp_n;
	logic miso_line;
	// pulled-up output line level seen by the host
	assign miso_line = miso_oe_n ? 1'b1 : miso;
	modport dev  (input cs_n, sck, mosi, wp_n, output miso, miso_oe_n);
	modport host (output cs_n, sck, mosi, wp_n, input miso_line);
endinterface

// file: core/snv_fifo.sv
// synchronous fifo with valid and ready on both sides
// assumes one clock; data out is valid while out valid is high
`timescale 1ns/1ps
module snv_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic         i_clk_sys,
	input  wire logic         i_nrst,
	// fill side
	input  wire logic [W-1:0] i_in_data,
	input  wire logic         i_in_valid,
	output      logic         o_in_ready,
	// drain side
	output      logic [W-1:0] o_out_data,
	output      logic         o_out_valid,
	input  wire logic         i_out_ready
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
		logic          full;
		logic          empty;
	} snv_fifo_st_t;
	snv_fifo_st_t r;
	snv_fifo_st_t next_r;
	logic [W-1:0] mem [0:DEPTH-1];
	logic push;
	logic pop;
	////////////////////////////////////////////////////////////////
	// pointer and flag update
	always_comb begin
		push   = i_in_valid & ~r.full;
		pop    = i_out_ready & ~r.empty;
		next_r = r;
		if (push)
			next_r.wp = r.wp + 1'b1;
		if (pop)
			next_r.rp = r.rp + 1'b1;
		if (push & ~pop)
			next_r.cnt = r.cnt + 1'b1;
		else if (pop & ~push)
			next_r.cnt = r.cnt - 1'b1;
		next_r.full  = (next_r.cnt == (AW+1)'(DEPTH));
		next_r.empty = (next_r.cnt == '0);
	end
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			r       <= '0;
			r.empty <= 1'b1;
		end else
			r <= next_r;
	end
	// storage has no reset
	always_ff @(posedge i_clk_sys) begin
		if (push)
			mem[r.wp] <= i_in_data;
	end
	assign o_in_ready  = ~r.full;
	assign o_out_valid = ~r.empty;
	assign o_out_data  = mem[r.rp];
endmodule

// file: core/snv_host.sv
// host end: serial master making the link clock by a divider
// assumes the user fills the tx fifo with command, address, data bytes
`timescale 1ns/1ps
module snv_host #(
	parameter int HALF  = snv_pkg::SCK_HALF_CYC,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_nrst,
	// link
	snv_if.host              bus,
	// transfer request
	input  wire logic        i_start,
	input  wire logic        i_mode3,
	input  wire logic        i_wp_n,
	input  wire logic [15:0] i_tx_len,
	input  wire logic [15:0] i_rx_len,
	// bytes to send
	input  wire logic [7:0]  i_tx_data,
	input  wire logic        i_tx_valid,
	output      logic        o_tx_ready,
	// bytes received
	output      logic [7:0]  o_rx_data,
	output      logic        o_rx_valid,
	output      logic        o_busy
);
	import snv_pkg::*;
	typedef struct packed {
		snv_hst_t    st;
		logic [7:0]  div;
		logic        sck;
		logic        cs_n;
		logic        mosi;
		logic        wp_n;
		logic [1:0]  miso_s;
		logic [7:0]  sh;
		logic [2:0]  bitc;
		logic [15:0] tx_left;
		logic [15:0] rx_left;
		logic        rxph;
		logic        mode3;
		logic [7:0]  rx_data;
		logic        rx_valid;
		logic        busy;
	} snv_host_st_t;
	snv_host_st_t r;
	snv_host_st_t next_r;
	logic [7:0] f_data;
	logic       f_valid;
	logic       f_ready;
	logic       tick;
	////////////////////////////////////////////////////////////////
	// outgoing byte buffer
	snv_fifo #(.W(8), .DEPTH(DEPTH)) u_fifo (
		.i_clk_sys  (i_clk_sys),
		.i_nrst     (i_nrst),
		.i_in_data  (i_tx_data),
		.i_in_valid (i_tx_valid),
		.o_in_ready (o_tx_ready),
		.o_out_data (f_data),
		.o_out_valid(f_valid),
		.i_out_ready(f_ready)
	);
	////////////////////////////////////////////////////////////////
	// clock divider and bit engine
	always_comb begin
		next_r          = r;
		f_ready         = 1'b0;
		next_r.rx_valid = 1'b0;
		next_r.miso_s   = {r.miso_s[0], bus.miso_line};
		next_r.wp_n     = i_wp_n;
		tick            = (r.div == 8'(HALF - 1));
		next_r.div      = tick ? 8'h00 : r.div + 8'h01;
		case (r.st)
		H_IDLE: begin
			if (i_start) begin
				// select goes low before any clock edge [R3] [R13]
				next_r.cs_n    = 1'b0;
				// clock keeps its level; a jump here is a false edge
				next_r.mode3   = i_mode3; // [R6]
				next_r.tx_left = i_tx_len;
				next_r.rx_left = i_rx_len;
				next_r.busy    = 1'b1;
				next_r.st      = H_LOAD;
			end
		end
		H_LOAD: begin
			next_r.div  = 8'h00;
			next_r.bitc = 3'h0;
			if (r.tx_left != 16'h0000) begin
				// command, address and data all come from the fifo [R7]
				if (f_valid) begin
					f_ready        = 1'b1;
					next_r.sh      = f_data;
					next_r.mosi    = f_data[7]; // [R16]
					next_r.rxph    = 1'b0;
					next_r.tx_left = r.tx_left - 16'h0001;
					next_r.sck     = 1'b0;
					next_r.st      = H_LO;
				end
			end else if (r.rx_left != 16'h0000) begin
				next_r.sh      = 8'h00;
				next_r.mosi    = 1'b0;
				next_r.rxph    = 1'b1;
				next_r.rx_left = r.rx_left - 16'h0001;
				next_r.sck     = 1'b0;
				next_r.st      = H_LO;
			end else
				next_r.st = H_TAIL;
		end
		H_LO: begin
			if (tick) begin
				next_r.sck = 1'b1;
				next_r.sh  = {r.sh[6:0], r.miso_s[1]};
				next_r.st  = H_HI;
			end
		end
		H_HI: begin
			if (tick) begin
				next_r.sck = 1'b0;
				if (r.bitc == BIT_LAST) begin
					// mode 3 ends on the last rise, no trailing edge [R6]
					if (r.mode3 && r.tx_left == 16'h0000 &&
						r.rx_left == 16'h0000)
						next_r.sck = 1'b1;
					next_r.rx_data  = r.sh;
					next_r.rx_valid = r.rxph;
					next_r.st       = H_LOAD;
				end else begin
					next_r.bitc = r.bitc + 3'h1;
					next_r.mosi = r.sh[7];
					next_r.st   = H_LO;
				end
			end
		end
		H_TAIL: begin
			if (tick) begin
				next_r.sck = r.mode3;
				next_r.st  = H_END;
			end
		end
		H_END: begin
			if (tick) begin
				next_r.cs_n = 1'b1;
				next_r.st   = H_GAP;
			end
		end
		H_GAP: begin
			if (tick) begin
				next_r.busy = 1'b0;
				next_r.st   = H_IDLE;
			end
		end
		default: next_r.st = H_IDLE;
		endcase
	end
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			r        <= '0;
			r.cs_n   <= 1'b1;
			r.wp_n   <= 1'b1;
			r.miso_s <= 2'b11;
		end else
			r <= next_r;
	end
	////////////////////////////////////////////////////////////////
	// outputs straight from the state register
	assign bus.cs_n   = r.cs_n;
	assign bus.sck    = r.sck;
	assign bus.mosi   = r.mosi;
	assign bus.wp_n   = r.wp_n;
	assign o_rx_data  = r.rx_data;
	assign o_rx_valid = r.rx_valid;
	assign o_busy     = r.busy;
endmodule

// file: tb/snv_properties.sv
// concurrent checks on the serial link between host and device ends
// assumes it sits beside the interface and sees its signals directly
`timescale 1ns/1ps
module snv_properties (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	// link
	input wire logic cs_n,
	input wire logic sck,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe_n,
	input wire logic wp_n,
	input wire logic miso_line
);
	logic       sck_q;
	logic [2:0] rise_cnt;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);
	////////////////////////////////////////////////////////////////
	// rising link clock edges inside one frame, modulo eight
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			sck_q    <= 1'b0;
			rise_cnt <= 3'h0;
		end else begin
			sck_q <= sck;
			if (cs_n)
				rise_cnt <= 3'h0;
			else if (!sck_q && sck)
				rise_cnt <= rise_cnt + 3'h1;
		end
	end
	////////////////////////////////////////////////////////////////
	// device side
	property p_standby; cs_n [*5] |-> miso_oe_n; endproperty
	a_standby: assert property (p_standby)
		else $error("output driven while deselected");
	property p_release; $rose(cs_n) |-> ##[0:6] miso_oe_n; endproperty
	a_release: assert property (p_release)
		else $error("output not released after deselect");
	property p_out_edge; !miso_oe_n && $changed(miso) |-> !sck; endproperty
	a_out_edge: assert property (p_out_edge)
		else $error("output changed while link clock high");
	property p_out_late;
		$fell(miso_oe_n) |-> !cs_n && rise_cnt == 3'h0;
	endproperty
	a_out_late: assert property (p_out_late)
		else $error("output driven inside a byte");
	// host side
	property p_mosi_hold; sck && $past(sck) && !cs_n |-> $stable(mosi);
	endproperty
	a_mosi_hold: assert property (p_mosi_hold)
		else $error("input data moved while clock high");
	property p_sel_first; $rose(sck) |-> !cs_n; endproperty
	a_sel_first: assert property (p_sel_first)
		else $error("clock rose while deselected");
	property p_low_half; $fell(sck) && !cs_n |-> !sck [*6]; endproperty
	a_low_half: assert property (p_low_half)
		else $error("link clock low phase too short");
	property p_frame_bytes; $rose(cs_n) |-> rise_cnt == 3'h0; endproperty
	a_frame_bytes: assert property (p_frame_bytes)
		else $error("frame not whole bytes");
	property p_wp_steady; !cs_n && !$past(cs_n) |-> $stable(wp_n);
	endproperty
	a_wp_steady: assert property (p_wp_steady)
		else $error("protect pin moved inside frame");
	// host data quiet while the device talks, so one line could serve
	property p_share_quiet; !miso_oe_n |-> !mosi; endproperty
	a_share_quiet: assert property (p_share_quiet)
		else $error("host data active while device drives");
endmodule

// file: tb/tb_spi_nvram_slave_front_end.sv
// bench: host and device ends joined, plus a bare device driven by hand
// assumes the package constants and the 250 MHz system clock
`timescale 1ns/1ps
module tb_spi_nvram_slave_front_end;
	import snv_pkg::*;
	logic        clk      = 1'b0;
	logic        nrst     = 1'b0;
	logic        start    = 1'b0;
	logic        mode3    = 1'b0;
	logic        wp_n     = 1'b1;
	logic [15:0] tx_len   = 16'h0000;
	logic [15:0] rx_len   = 16'h0000;
	logic [7:0]  tx_data  = 8'h00;
	logic        tx_valid = 1'b0;
	logic        tx_ready, rx_valid, busy, active, latch, prot;
	logic        active2, latch2, prot2;
	logic [7:0]  rx_data;
	logic [7:0]  tx_q[$];
	logic [7:0]  exp_q[$];
	logic [7:0]  mem[12];
	logic [7:0]  e;
	int          error_cnt = 0;
	int          tests_run = 0;
	snv_if u_snv_if ();
	snv_if u_snv_if_2 ();
	snv_host u_snv_host (.i_clk_sys(clk), .i_nrst(nrst), .bus(u_snv_if),
		.i_start(start), .i_mode3(mode3), .i_wp_n(wp_n), .i_tx_len(tx_len),
		.i_rx_len(rx_len), .i_tx_data(tx_data), .i_tx_valid(tx_valid),
		.o_tx_ready(tx_ready), .o_rx_data(rx_data), .o_rx_valid(rx_valid),
		.o_busy(busy));
	snv_dev u_snv_dev (.i_clk_sys(clk), .i_nrst(nrst), .bus(u_snv_if),
		.o_active(active), .o_write_latch(latch),
		.o_status_protect_enable_bit(prot));
	snv_dev u_snv_dev_2 (.i_clk_sys(clk), .i_nrst(nrst), .bus(u_snv_if_2),
		.o_active(active2), .o_write_latch(latch2),
		.o_status_protect_enable_bit(prot2));
	snv_properties u_snv_properties (.i_clk_sys(clk), .i_nrst(nrst),
		.cs_n(u_snv_if.cs_n), .sck(u_snv_if.sck), .mosi(u_snv_if.mosi),
		.miso(u_snv_if.miso), .miso_oe_n(u_snv_if.miso_oe_n),
		.wp_n(u_snv_if.wp_n), .miso_line(u_snv_if.miso_line));
	////////////////////////////////////////////////////////////////
	// system clock
	always #2 clk = ~clk;
	// compare each received byte with the oldest note
	always begin
		@(posedge clk);
		#1;
		if (rx_valid === 1'b1) begin
			if (exp_q.size() == 0)
				check(8'(exp_q.size()), 8'h01);
			else
				check(rx_data, exp_q.pop_front());
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		tests_run++;
		if (seen !== want) begin
			error_cnt++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic give_up();
		error_cnt++;
		$display("mismatch at %0t: wait ran out", $time);
		conclude();
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// fill the fifo with the queued bytes, run one frame, wait its end
	task automatic run(input logic m3, input int rx_n);
		int n;
		mode3 = m3;
		tx_len = 16'(tx_q.size());
		rx_len = 16'(rx_n);
		while (tx_q.size() > 0) begin
			for (n = 0; tx_ready !== 1'b1; n++) begin
				if (n > 100)
					give_up();
				tick(1);
			end
			tx_data = tx_q.pop_front();
			tx_valid = 1'b1;
			tick(1);
		end
		tx_valid = 1'b0;
		if (tx_len == 16'h0010)
			check({7'h00, tx_ready}, 8'h00);
		start = 1'b1;
		tick(1);
		start = 1'b0;
		tick(20);
		check({7'h00, active}, 8'h01);
		for (n = 0; busy !== 1'b0; n++) begin
			if (n > 5000)
				give_up();
			tick(1);
		end
		check({7'h00, active}, 8'h00);
		check(8'(exp_q.size()), 8'h00);
	endtask
	// hand-driven mode 0 frame on the bare device, nb bits of b
	task automatic bang(input logic [7:0] b, input int nb, input logic cs);
		u_snv_if_2.cs_n = cs;
		for (int i = 0; i < nb; i++) begin
			u_snv_if_2.mosi = b[7-i];
			tick(8);
			u_snv_if_2.sck = 1'b1;
			tick(8);
			u_snv_if_2.sck = 1'b0;
		end
		tick(8);
		u_snv_if_2.cs_n = 1'b1;
		tick(8);
	endtask
	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		u_snv_if_2.cs_n = 1'b1;
		u_snv_if_2.sck = 1'b0;
		u_snv_if_2.mosi = 1'b0;
		u_snv_if_2.wp_n = 1'b1;
		void'($urandom(32'h6040));
		tick(20);
		nrst = 1'b1;
		tick(2);
		// status after reset, then latch set, both clock modes
		tx_q = '{OP_RD_STAT};
		exp_q.push_back({SR_INIT, 2'b00});
		run(1'b0, 1);
		tx_q = '{OP_WR_EN};
		run(1'b1, 0);
		check({7'h00, latch}, 8'h01);
		tx_q = '{OP_RD_STAT};
		exp_q.push_back({SR_INIT, 2'b10});
		run(1'b1, 0 + 1);
		// full fifo write across the top of the array, read back
		tx_q = '{OP_WR_MEM, 8'hc3, 8'hff, 8'hfa};
		foreach (mem[i]) begin
			mem[i] = 8'($urandom);
			tx_q.push_back(mem[i]);
		end
		run(1'b1, 0);
		tx_q = '{OP_RD_MEM, 8'h03, 8'hff, 8'hfa};
		foreach (mem[i])
			exp_q.push_back(mem[i]);
		run(1'b0, 12);
		tx_q = '{OP_RD_MEM, 8'h00, 8'h00, 8'h00};
		for (int i = 6; i < 12; i++)
			exp_q.push_back(mem[i]);
		run(1'b1, 6);
		// serial number, first byte holds the top bits
		tx_q = '{OP_RD_SER};
		for (int i = 7; i >= 0; i--)
			exp_q.push_back(SER_INIT[8*i +: 8]);
		run(1'b0, 8);
		// serial number rewrite while the latch is set, read back
		tx_q = '{OP_WR_SER};
		for (int i = 0; i < 8; i++)
			tx_q.push_back(mem[i]);
		run(1'b1, 0);
		tx_q = '{OP_RD_SER};
		for (int i = 0; i < 8; i++)
			exp_q.push_back(mem[i]);
		run(1'b0, 8);
		// status writes under pin and bit protection
		for (int i = 0; i < 3; i++) begin
			wp_n = (i != 1);
			e = (i == 2) ? 8'h02 : 8'h8e;
			tx_q = '{OP_WR_STAT, (i == 0) ? 8'h8f : 8'h00};
			run(1'b0, 0);
			tx_q = '{OP_RD_STAT};
			exp_q.push_back(e);
			run(i[0], 1);
			check({7'h00, prot}, {7'h00, e[7]});
		end
		// cleared latch refuses a memory write
		tx_q = '{OP_WR_DIS};
		run(1'b1, 0);
		check({7'h00, latch}, 8'h00);
		tx_q = '{OP_WR_MEM, 8'h00, 8'h00, 8'h00, ~mem[6]};
		run(1'b0, 0);
		tx_q = '{OP_RD_MEM, 8'h00, 8'h00, 8'h00};
		exp_q.push_back(mem[6]);
		run(1'b0, 1);
		// bare device: deselected clocks and a short code do nothing
		bang(OP_WR_EN, 8, 1'b1);
		check({7'h00, latch2}, 8'h00);
		check({6'h00, active2, prot2}, 8'h00);
		bang(OP_WR_EN, 7, 1'b0);
		check({7'h00, latch2}, 8'h00);
		bang(OP_WR_EN, 8, 1'b0);
		check({7'h00, latch2}, 8'h01);
		tick(10);
		conclude();
	end
endmodule
